// File: logic/drac_pkg.sv
// Purpose: Shared constants for the display memory address control block.
// Assumes: 32-bit APB register bus, one clock.
// Notes:   Byte offsets are word aligned.
package drac_pkg;
  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int unsigned NUM_PAGES       = 132;
  localparam int unsigned NUM_COLS        = 132;
  localparam int unsigned MEM_WORDS       = NUM_PAGES * NUM_COLS;
  localparam logic [14:0] ROW_STRIDE      = 15'h0084;
  localparam logic [7:0]  LAST_ADDR       = 8'h83;
  localparam logic [7:0]  ADDR_STEP       = 8'h01;
  localparam int unsigned BLOCK_SHIFT     = 2;
  localparam int unsigned PIX_W           = 12;
  localparam int unsigned FIFO_DEPTH      = 16;

  // ****************************************
  // Pixel word fields
  // ****************************************
  localparam int unsigned RED_HI          = 11;
  localparam int unsigned RED_LO          = 8;
  localparam int unsigned GRN_HI          = 7;
  localparam int unsigned GRN_LO          = 4;
  localparam int unsigned BLU_HI          = 3;
  localparam int unsigned BLU_LO          = 0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_PAGE_WIN    = 8'h04;
  localparam logic [7:0]  OFF_COL_WIN     = 8'h08;
  localparam logic [7:0]  OFF_DATA        = 8'h0c;
  localparam logic [7:0]  OFF_STATUS      = 8'h10;
  localparam int unsigned CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RST        = 6'h00;
  localparam int unsigned CTL_SCAN_COL    = 0;
  localparam int unsigned CTL_PAGE_INV    = 1;
  localparam int unsigned CTL_COL_INV     = 2;
  localparam int unsigned CTL_RB_SWAP     = 3;
  localparam int unsigned CTL_DISP_ON     = 4;
  localparam int unsigned CTL_DISP_INV    = 5;
  localparam int unsigned WIN_START_LO    = 0;
  localparam int unsigned WIN_END_LO      = 8;
  localparam int unsigned STAT_PAGE_LO    = 0;
  localparam int unsigned STAT_COL_LO     = 8;
  localparam int unsigned STAT_EMPTY      = 16;
  localparam int unsigned STAT_FULL       = 17;

  typedef enum logic {
    ANS_IDLE = 1'b0,
    ANS_DONE = 1'b1
  } drac_ans_e;

  // Exchange red and blue nibbles when asked
  function automatic logic [PIX_W-1:0] rb_swap(input logic [PIX_W-1:0] p, input logic en);
    logic [PIX_W-1:0] s;
    s = p;
    if (en) begin
      s[RED_HI:RED_LO] = p[BLU_HI:BLU_LO];
      s[BLU_HI:BLU_LO] = p[RED_HI:RED_LO];
    end
    return s;
  endfunction
endpackage

// File: logic/drac_fifo.sv
// Purpose: Valid/ready FIFO between host writes and display memory.
// Assumes: Depth is a power of two.
// Notes:   Extra pointer bit tells full from empty.
module drac_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign out_valid_o = (wr_q != rd_q);
  assign in_ready_o  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// File: logic/drac_top.sv
// Purpose: Display memory with windowed page/column address counters.
// Assumes: APB master on CLOCK_I; display fetch logic on the same clock.
// Notes:   Display fetch owns the memory port; host drain waits for it.
//
// Operation
// - Pixel word: red bits 11..8, green 7..4, blue 3..0.
// - Control option swaps red and blue positions of the pixel word.
// - Page window limits page addressing for host access.
// - Page scan: after end page, column plus one, page back to start.
// - Memory holds 132 pages, one per display line.
// - Page scan reads wrap the same way as writes.
// - Page inversion maps page 131 to the first display line.
// - Column window limits column addressing.
// - Column scan: after end column, page plus one, column back to start.
// - Column scan reads advance column and wrap to start column.
// - Column inversion maps column 131 to the first segment triplet.
// - Host access runs independently of the display latch transfer; here the write drain stalls while DISP_FETCH_I is high.
// - Pages grouped four to a block; areas given in whole blocks.
// - Normal/inverse and on/off act on latch output only.
//
// Local design decisions: the register addresses and register access over APB.
module drac_top #(
  parameter int unsigned FIFO_DEPTH = drac_pkg::FIFO_DEPTH
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        DISP_FETCH_I,
  input  wire logic [7:0]  DISP_LINE_I,
  input  wire logic [7:0]  DISP_COL_I,
  output logic [11:0]      DISP_PIXEL_O,
  output logic [5:0]       DISP_BLOCK_O
);
  localparam int unsigned PW = drac_pkg::PIX_W;

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  // ****************************************
  // State
  // ****************************************
  logic [PW-1:0]             mem_q [drac_pkg::MEM_WORDS];
  logic [drac_pkg::CTRL_W-1:0] ctl_q;
  logic [7:0]                pstart_q;
  logic [7:0]                pend_q;
  logic [7:0]                cstart_q;
  logic [7:0]                cend_q;
  logic [7:0]                page_q;
  logic [7:0]                col_q;
  logic [7:0]                page_d;
  logic [7:0]                col_d;
  drac_pkg::drac_ans_e       ans_q;
  logic [31:0]               prdata_q;
  logic [PW-1:0]             latch_q;
  logic [11:0]               pixel_q;
  logic [5:0]                block_q;

  // ****************************************
  // APB decode
  // ****************************************
  logic          acc;
  logic          hit_ctrl;
  logic          hit_pwin;
  logic          hit_cwin;
  logic          hit_data;
  logic          hit_stat;
  logic          bad_addr;
  logic [7:0]    wstart;
  logic [7:0]    wend;
  logic          win_bad;
  logic          wr_rdy;
  logic          done;
  logic          wr_ok;
  logic          read_go;
  logic          rd_adv;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [PW-1:0] fifo_out_data;
  logic          pop;
  logic [14:0]   host_idx;
  logic [31:0]   rd_mux;

  assign acc      = PSEL_I && PENABLE_I;
  assign hit_ctrl = (PADDR_I == drac_pkg::OFF_CTRL);
  assign hit_pwin = (PADDR_I == drac_pkg::OFF_PAGE_WIN);
  assign hit_cwin = (PADDR_I == drac_pkg::OFF_COL_WIN);
  assign hit_data = (PADDR_I == drac_pkg::OFF_DATA);
  assign hit_stat = (PADDR_I == drac_pkg::OFF_STATUS);
  assign bad_addr = !(hit_ctrl || hit_pwin || hit_cwin || hit_data || hit_stat);
  assign wstart   = PWDATA_I[drac_pkg::WIN_START_LO +: 8];
  assign wend     = PWDATA_I[drac_pkg::WIN_END_LO +: 8];
  // Windows outside the memory or reversed are refused
  assign win_bad  = (hit_pwin || hit_cwin) && ((wstart > wend) || (wend > drac_pkg::LAST_ADDR));

  // Setup writes wait for pending pixels so counters never move under the drain
  always_comb begin
    if (bad_addr) begin
      wr_rdy = 1'b1;
    end else if (hit_data) begin
      wr_rdy = fifo_in_ready;
    end else if (hit_stat) begin
      wr_rdy = 1'b1;
    end else begin
      wr_rdy = !fifo_out_valid;
    end
  end

  assign PREADY_O  = acc && (PWRITE_I ? wr_rdy : (ans_q == drac_pkg::ANS_DONE));
  assign PSLVERR_O = PREADY_O && (bad_addr || (PWRITE_I && win_bad));
  assign done      = acc && PREADY_O;
  assign wr_ok     = done && PWRITE_I && !PSLVERR_O;
  // Data reads wait until every earlier write has reached memory
  assign read_go   = acc && !PWRITE_I && (ans_q == drac_pkg::ANS_IDLE) && (!hit_data || !fifo_out_valid);
  assign rd_adv    = done && !PWRITE_I && hit_data;
  assign PRDATA_O  = prdata_q;

  // ****************************************
  // Write buffer
  // ****************************************
  // Display fetch has the memory port; the drain stalls and the FIFO fills
  assign pop = fifo_out_valid && !DISP_FETCH_I;

  drac_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .in_valid_i  (acc && PWRITE_I && hit_data),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (PWDATA_I[PW-1:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!DISP_FETCH_I),
    .out_data_o  (fifo_out_data)
  );

  // ****************************************
  // Control and window registers
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ctl_q <= drac_pkg::CTRL_RST;
    end else if (wr_ok && hit_ctrl) begin
      ctl_q <= PWDATA_I[drac_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pstart_q <= '0;
      pend_q   <= drac_pkg::LAST_ADDR;
      cstart_q <= '0;
      cend_q   <= drac_pkg::LAST_ADDR;
    end else if (wr_ok && hit_pwin) begin
      pstart_q <= wstart;
      pend_q   <= wend;
    end else if (wr_ok && hit_cwin) begin
      cstart_q <= wstart;
      cend_q   <= wend;
    end
  end

  // ****************************************
  // Address counters
  // ****************************************
  always_comb begin
    page_d = page_q;
    col_d  = col_q;
    if (ctl_q[drac_pkg::CTL_SCAN_COL]) begin
      if (col_q == cend_q) begin
        col_d  = cstart_q;
        page_d = (page_q == pend_q) ? pstart_q : page_q + drac_pkg::ADDR_STEP;
      end else begin
        col_d = col_q + drac_pkg::ADDR_STEP;
      end
    end else begin
      if (page_q == pend_q) begin
        page_d = pstart_q;
        col_d  = (col_q == cend_q) ? cstart_q : col_q + drac_pkg::ADDR_STEP;
      end else begin
        page_d = page_q + drac_pkg::ADDR_STEP;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      page_q <= '0;
      col_q  <= '0;
    end else if (wr_ok && hit_pwin) begin
      page_q <= wstart;
    end else if (wr_ok && hit_cwin) begin
      col_q <= wstart;
    end else if (pop || rd_adv) begin
      page_q <= page_d;
      col_q  <= col_d;
    end
  end

  // ****************************************
  // Display memory, host side
  // ****************************************
  assign host_idx = 15'(page_q) * drac_pkg::ROW_STRIDE + 15'(col_q);

  always_ff @(posedge CLOCK_I) begin
    if (pop) begin
      mem_q[host_idx] <= drac_pkg::rb_swap(fifo_out_data, ctl_q[drac_pkg::CTL_RB_SWAP]);
    end
  end

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[drac_pkg::CTRL_W-1:0] = ctl_q;
    end else if (hit_pwin) begin
      rd_mux[drac_pkg::WIN_START_LO +: 8] = pstart_q;
      rd_mux[drac_pkg::WIN_END_LO +: 8]   = pend_q;
    end else if (hit_cwin) begin
      rd_mux[drac_pkg::WIN_START_LO +: 8] = cstart_q;
      rd_mux[drac_pkg::WIN_END_LO +: 8]   = cend_q;
    end else if (hit_data) begin
      rd_mux[PW-1:0] = drac_pkg::rb_swap(mem_q[host_idx], ctl_q[drac_pkg::CTL_RB_SWAP]);
    end else if (hit_stat) begin
      rd_mux[drac_pkg::STAT_PAGE_LO +: 8] = page_q;
      rd_mux[drac_pkg::STAT_COL_LO +: 8]  = col_q;
      rd_mux[drac_pkg::STAT_EMPTY]        = !fifo_out_valid;
      rd_mux[drac_pkg::STAT_FULL]         = !fifo_in_ready;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ans_q    <= drac_pkg::ANS_IDLE;
      prdata_q <= '0;
    end else begin
      unique case (ans_q)
        drac_pkg::ANS_IDLE: begin
          if (read_go) begin
            ans_q    <= drac_pkg::ANS_DONE;
            prdata_q <= rd_mux;
          end
        end
        drac_pkg::ANS_DONE: begin
          if (done) begin
            ans_q <= drac_pkg::ANS_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Display latch side
  // ****************************************
  logic [7:0]  dpage;
  logic [7:0]  dcol;
  logic        dvalid;
  logic [14:0] disp_idx;

  assign dpage    = ctl_q[drac_pkg::CTL_PAGE_INV] ? drac_pkg::LAST_ADDR - DISP_LINE_I : DISP_LINE_I;
  assign dcol     = ctl_q[drac_pkg::CTL_COL_INV] ? drac_pkg::LAST_ADDR - DISP_COL_I : DISP_COL_I;
  assign dvalid   = (DISP_LINE_I <= drac_pkg::LAST_ADDR) && (DISP_COL_I <= drac_pkg::LAST_ADDR);
  assign disp_idx = 15'(dpage) * drac_pkg::ROW_STRIDE + 15'(dcol);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      latch_q <= '0;
      block_q <= '0;
    end else if (DISP_FETCH_I) begin
      latch_q <= dvalid ? mem_q[disp_idx] : '0;
      block_q <= 6'(dpage >> drac_pkg::BLOCK_SHIFT);
    end
  end

  // Blanking and inversion touch only the latch copy, memory stays intact
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pixel_q <= '0;
    end else if (!ctl_q[drac_pkg::CTL_DISP_ON]) begin
      pixel_q <= '0;
    end else begin
      pixel_q <= ctl_q[drac_pkg::CTL_DISP_INV] ? ~latch_q : latch_q;
    end
  end

  assign DISP_PIXEL_O = pixel_q;
  assign DISP_BLOCK_O = block_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_page_wrap: assert property ((pop || rd_adv) && !ctl_q[drac_pkg::CTL_SCAN_COL] && page_q == pend_q
      |=> page_q == $past(pstart_q) && col_q == ($past(col_q) == $past(cend_q) ? $past(cstart_q)
          : $past(col_q) + drac_pkg::ADDR_STEP))
    else $error("page scan wrap wrong");

  a_read_page: assert property (rd_adv && !ctl_q[drac_pkg::CTL_SCAN_COL] && page_q != pend_q
      |=> page_q == $past(page_q) + drac_pkg::ADDR_STEP && col_q == $past(col_q))
    else $error("page scan read step wrong");

  a_col_wrap: assert property (pop && ctl_q[drac_pkg::CTL_SCAN_COL] && col_q == cend_q
      |=> col_q == $past(cstart_q) && page_q == ($past(page_q) == $past(pend_q) ? $past(pstart_q)
          : $past(page_q) + drac_pkg::ADDR_STEP))
    else $error("column scan wrap wrong");

  a_read_col: assert property (rd_adv && ctl_q[drac_pkg::CTL_SCAN_COL] && col_q != cend_q
      |=> col_q == $past(col_q) + drac_pkg::ADDR_STEP && page_q == $past(page_q))
    else $error("column scan read step wrong");

  a_page_range: assert property (pop |-> page_q >= pstart_q && page_q <= pend_q)
    else $error("page outside window");

  a_col_range: assert property (pop |-> col_q >= cstart_q && col_q <= cend_q)
    else $error("column outside window");

  a_win_load: assert property (wr_ok && hit_pwin |=> page_q == $past(wstart) && pend_q == $past(wend))
    else $error("page window did not load counter");

  a_read_order: assert property (acc && !PWRITE_I && hit_data && PREADY_O |-> !fifo_out_valid)
    else $error("data read overtook pending writes");

  a_disp_blank: assert property (!ctl_q[drac_pkg::CTL_DISP_ON] ##1 !ctl_q[drac_pkg::CTL_DISP_ON]
      |-> DISP_PIXEL_O == '0)
    else $error("pixel not blanked with display off");

  a_block_inv: assert property (DISP_FETCH_I && ctl_q[drac_pkg::CTL_PAGE_INV] && dvalid
      |=> DISP_BLOCK_O == 6'((drac_pkg::LAST_ADDR - $past(DISP_LINE_I)) >> drac_pkg::BLOCK_SHIFT))
    else $error("inverted block index wrong");

  a_swap_write: assert property (pop && ctl_q[drac_pkg::CTL_RB_SWAP]
      |=> mem_q[$past(host_idx)][drac_pkg::BLU_HI:drac_pkg::BLU_LO]
          == $past(fifo_out_data[drac_pkg::RED_HI:drac_pkg::RED_LO]))
    else $error("red and blue not exchanged");

  c_page_wrap: cover property (pop && !ctl_q[drac_pkg::CTL_SCAN_COL] && page_q == pend_q);
  c_col_wrap:  cover property (pop && ctl_q[drac_pkg::CTL_SCAN_COL] && col_q == cend_q);
  c_fifo_full: cover property (acc && PWRITE_I && hit_data && !fifo_in_ready);
  c_data_read: cover property (rd_adv);
endmodule

// File: test/drac_host.sv
// Purpose: APB master standing in for the host processor.
// Assumes: Slave answers with PREADY; no fixed latency is assumed.
// Notes:   Released address and data lines are inverted, never held.
module drac_host (
  input  wire logic        clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'hff;
    pwdata_o  = 32'h0;
  end

  // Request stands until the rising edge that sees ready; answer taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule

// File: test/drac_top_bench.sv
// Purpose: Self-checking bench for the display memory address control.
// Assumes: FIFO depth 4 so a held display fetch fills it quickly.
// Notes:   Expected pixels come from a bench-side memory model.
module drac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fetch;
  logic [7:0]  line;
  logic [7:0]  coln;
  logic [11:0] pix;
  logic [5:0]  blk;
  int          errors;
  int          checks_done;
  int          cyc;
  logic [11:0] mem [int];
  logic [7:0]  pg, cl, ps, pe, cs, ce, r8, c8;
  logic        scan, swp, noise, e;
  logic [31:0] q, er;
  logic [11:0] v;
  logic        fx;
  logic [7:0]  lx;
  logic [7:0]  cx;
  logic [16:0] nz;

  drac_top #(.FIFO_DEPTH(4)) dut (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DISP_FETCH_I(fetch), .DISP_LINE_I(line), .DISP_COL_I(coln),
    .DISP_PIXEL_O(pix), .DISP_BLOCK_O(blk));

  drac_host host (
    .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  always #2 clk = ~clk;

  // Random display fetches racing host traffic; scripted fetches otherwise
  always @(posedge clk) begin
    nz <= 17'($urandom);
  end

  always_comb begin
    {fetch, line, coln} = noise ? nz : {fx, lx, cx};
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] sw(input logic [11:0] p);
    return {p[3:0], p[7:4], p[11:8]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    er = {31'h0, e};
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
    er = {31'h0, e};
  endtask

  task automatic step();
    if (scan) begin
      if (cl == ce) begin
        cl = cs;
        pg = (pg == pe) ? ps : pg + 8'h01;
      end else begin
        cl = cl + 8'h01;
      end
    end else if (pg == pe) begin
      pg = ps;
      cl = (cl == ce) ? cs : cl + 8'h01;
    end else begin
      pg = pg + 8'h01;
    end
  endtask

  task automatic setw(input bit pgw, input logic [7:0] s, input logic [7:0] en);
    wr(pgw ? drac_pkg::OFF_PAGE_WIN : drac_pkg::OFF_COL_WIN, {16'h0, en, s});
    chk(er, 32'h0);
    if (pgw) {ps, pe, pg} = {s, en, s};
    else {cs, ce, cl} = {s, en, s};
  endtask

  task automatic px_w(input logic [11:0] d);
    wr(drac_pkg::OFF_DATA, {20'h0, d});
    mem[int'(pg) * 132 + int'(cl)] = swp ? sw(d) : d;
    step();
  endtask

  task automatic px_r();
    rd(drac_pkg::OFF_DATA);
    v = mem[int'(pg) * 132 + int'(cl)];
    chk(q, {20'h0, swp ? sw(v) : v});
    step();
  endtask

  task automatic drain();
    q = 32'h0;
    for (int i = 0; i < 40 && q[16] !== 1'b1; i++) rd(drac_pkg::OFF_STATUS);
    chk(q[16], 1'b1);
  endtask

  task automatic look(input logic [7:0] ln, input logic [7:0] cn, input logic [11:0] xp,
                      input logic [5:0] xb);
    @(posedge clk);
    fx <= 1'b1;
    lx <= ln;
    cx <= cn;
    @(posedge clk);
    fx <= 1'b0;
    #1;
    chk({26'h0, blk}, {26'h0, xb});
    @(posedge clk);
    #1;
    chk({20'h0, pix}, {20'h0, xp});
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {clk, fx, lx, cx, scan, swp, noise, errors, checks_done} = '0;
    rst = 1'b1;
    void'($urandom(32'h7a04));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(drac_pkg::OFF_CTRL);
    chk(q, 32'h0);
    rd(drac_pkg::OFF_PAGE_WIN);
    chk(q, 32'h8300);
    rd(drac_pkg::OFF_COL_WIN);
    chk(q, 32'h8300);
    rd(drac_pkg::OFF_STATUS);
    chk(q, 32'h10000);
    rd(8'h20);
    chk(er | q, 32'h1);
    wr(drac_pkg::OFF_PAGE_WIN, 32'h0105);
    chk(er, 32'h1);
    wr(drac_pkg::OFF_COL_WIN, 32'h8400);
    chk(er, 32'h1);
    {ps, pe, cs, ce} = {8'h0, 8'h83, 8'h0, 8'h83};
    for (int s = 0; s < 2; s++) begin
      scan = s[0];
      wr(drac_pkg::OFF_CTRL, {31'h0, scan} | 32'h10);
      r8 = 8'($urandom % 130);
      c8 = 8'($urandom % 129);
      noise <= 1'b1;
      setw(1'b1, r8, r8 + 8'h01);
      setw(1'b0, c8, c8 + 8'h02);
      repeat (7) px_w(12'($urandom));
      noise <= 1'b0;
      drain();
      rd(drac_pkg::OFF_STATUS);
      chk(q[15:0], {cl, pg});
      setw(1'b1, r8, r8 + 8'h01);
      setw(1'b0, c8, c8 + 8'h02);
      rd(drac_pkg::OFF_STATUS);
      chk(q[15:0], {c8, r8});
      repeat (7) px_r();
    end
    scan = 1'b0;
    wr(drac_pkg::OFF_CTRL, 32'h10);
    setw(1'b1, 8'h83, 8'h83);
    setw(1'b0, 8'h83, 8'h83);
    v = 12'($urandom);
    px_w(v);
    drain();
    look(8'h83, 8'h83, v, 6'h20);
    wr(drac_pkg::OFF_CTRL, 32'h16);
    look(8'h00, 8'h00, v, 6'h20);
    wr(drac_pkg::OFF_CTRL, 32'h30);
    look(8'h83, 8'h83, ~v, 6'h20);
    wr(drac_pkg::OFF_CTRL, 32'h00);
    look(8'h83, 8'h83, 12'h0, 6'h20);
    wr(drac_pkg::OFF_CTRL, 32'h10);
    look(8'h83, 8'h83, v, 6'h20);
    swp = 1'b1;
    wr(drac_pkg::OFF_CTRL, 32'h18);
    setw(1'b1, 8'h83, 8'h83);
    v = 12'h5a3;
    px_w(v);
    drain();
    look(8'h83, 8'h83, 12'h3a5, 6'h20);
    setw(1'b1, 8'h83, 8'h83);
    px_r();
    swp = 1'b0;
    wr(drac_pkg::OFF_CTRL, 32'h10);
    setw(1'b1, 8'h00, 8'h03);
    setw(1'b0, 8'h00, 8'h83);
    @(posedge clk);
    fx <= 1'b1;
    repeat (4) px_w(12'($urandom));
    rd(drac_pkg::OFF_STATUS);
    chk(q[17:16], 2'b10);
    @(posedge clk);
    fx <= 1'b0;
    drain();
    for (int i = 0; i < 4; i++) look(8'(i), 8'h00, mem[i * 132], 6'h00);
    end_sim();
  end
endmodule
